// ---- core/cpu_core_map.svh ----
// address map, field positions, reset values and step sizes of the cpu core
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH

`define REG_COUNT        32
`define REGS_END         8'h1f
`define IO_BASE          8'h20
`define IO_END           8'h5f
`define EXT_IO_BASE      8'h60
`define EXT_IO_END       8'hff
`define SRAM_BASE        16'h0100
`define SRAM_END         16'h02ff
`define PTR_X_REG        5'h1a
`define PTR_Y_REG        5'h1c
`define PTR_Z_REG        5'h1e
`define IO_SP_LOW        6'h3d
`define IO_SP_HIGH       6'h3e
`define IO_STATUS        6'h3f
`define SP_RESET         16'h02ff
`define STEP_BYTE        16'h0001
`define STEP_RETURN      16'h0002
`define FLAG_C           0
`define FLAG_Z           1
`define FLAG_N           2
`define FLAG_V           3
`define FLAG_S           4
`define FLAG_H           5
`define FLAG_T           6
`define FLAG_I           7
`define BOOT_START       16'h1800

`endif

// ---- core/cpu_core_pkg.sv ----
// types shared by the cpu core files
package cpu_core_pkg;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_MOV, ALU_COM, ALU_INC, ALU_DEC, ALU_LSR, ALU_SWAP, ALU_PASS
  } alu_op_t;

  typedef enum logic [1:0] {
    PTR_PLAIN, PTR_POST_INC, PTR_PRE_DEC, PTR_DISP
  } ptr_mode_t;

  typedef enum logic [2:0] {
    STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RETURN, STK_IRQ, STK_IRET
  } stack_op_t;

  typedef enum logic [1:0] {
    SPACE_REGS, SPACE_IO, SPACE_EXT_IO, SPACE_SRAM
  } space_t;

endpackage

// ---- core/regfile_if.sv ----
// working register file access bundle between core and register array
`timescale 1ns/1ps
`default_nettype none
interface regfile_if;
  logic [4:0]  rdAddrA;
  logic [4:0]  rdAddrB;
  logic [7:0]  rdDataA;
  logic [7:0]  rdDataB;
  logic        wrEn;
  logic        wrWide;
  logic [4:0]  wrAddr;
  logic [15:0] wrData;
  logic [47:0] ptrPairs;
  modport core  (output rdAddrA, output rdAddrB, output wrEn, output wrWide,
                 output wrAddr, output wrData,
                 input rdDataA, input rdDataB, input ptrPairs);
  modport array (input rdAddrA, input rdAddrB, input wrEn, input wrWide,
                 input wrAddr, input wrData,
                 output rdDataA, output rdDataB, output ptrPairs);
endinterface
`default_nettype wire

// ---- core/work_reg_array.sv ----
// 32 x 8 working register array, two read ports, byte or word write
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_map.svh"
module work_reg_array (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // access
  regfile_if.array rf
);
  logic [7:0] regs      [`REG_COUNT];
  logic [7:0] next_regs [`REG_COUNT];

  // reads are combinational so operand fetch, op and write fit one cycle
  assign rf.rdDataA  = regs[rf.rdAddrA];
  assign rf.rdDataB  = regs[rf.rdAddrB];
  assign rf.ptrPairs = {regs[31], regs[30], regs[29], regs[28], regs[27], regs[26]};

  always_comb begin
    next_regs = regs;
    if (rf.wrEn) begin
      if (rf.wrWide) begin
        // word write lands on an even pair, low byte first
        next_regs[{rf.wrAddr[4:1], 1'b0}] = rf.wrData[7:0];
        next_regs[{rf.wrAddr[4:1], 1'b1}] = rf.wrData[15:8];
      end else begin
        next_regs[rf.wrAddr] = rf.wrData[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      regs <= next_regs;
    end
  end
endmodule
`default_nettype wire

// ---- core/stack_ptr_unit.sv ----
// stack pointer with byte-wise writes and push, pop, call and return steps
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_map.svh"
module stack_ptr_unit
  import cpu_core_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // control
  input  wire cpu_core_pkg::stack_op_t stackOp,
  input  wire logic                  wrLow,
  input  wire logic                  wrHigh,
  input  wire logic [7:0]            wrByte,
  // state
  output var  logic [15:0]           stackPointer
);
  logic [15:0] next_stackPointer;

  always_comb begin
    next_stackPointer = stackPointer;
    unique case (stackOp)
      STK_PUSH:                   next_stackPointer = stackPointer - `STEP_BYTE;
      STK_POP:                    next_stackPointer = stackPointer + `STEP_BYTE;
      STK_CALL, STK_IRQ:          next_stackPointer = stackPointer - `STEP_RETURN;
      STK_RETURN, STK_IRET:       next_stackPointer = stackPointer + `STEP_RETURN;
      default:                    next_stackPointer = stackPointer;
    endcase
    // each byte write stands on its own
    if (wrLow)  next_stackPointer[7:0]  = wrByte;
    if (wrHigh) next_stackPointer[15:8] = wrByte;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stackPointer <= `SP_RESET;
    end else begin
      stackPointer <= next_stackPointer;
    end
  end
endmodule
`default_nettype wire

// ---- core/cpu_regfile_stack_core.sv ----
// cpu core datapath: register file, pointers, data map, flags, stack, prefetch
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_map.svh"

// Overview of operation
// - 32 byte registers, single cycle access
// - next instruction fetched while current executes
// - read two, operate, write back, one cycle
// - byte and word read and write configurations
// - top six registers form three pointers
// - pointers: displacement, post-increment, pre-decrement
// - third pointer addresses program memory tables
// - register n sits at data address n
// - 64 io locations aliased at 0x20-0x5f
// - extended io 0x60-0xff only by data access
// - alu ops register, immediate or single
// - flags updated after every alu op except pass
// - flags never saved on interrupt entry
// - one or two word instructions, full reach
// - return address low byte pushed on call, interrupt
// - push decrements, pop increments by one
// - call decrements, return increments by two
// - stack pointer is two io bytes
// - lowest pending vector served first
// - program write accepted only from boot
// - interrupt clears enable, interrupt return sets it
module cpu_regfile_stack_core
  import cpu_core_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // program memory
  output logic [15:0]                  progAddr,
  input  wire logic [15:0]             progData,
  output logic                         progWriteOk,
  // decoded execute controls
  input  wire logic                    exValid,
  input  wire cpu_core_pkg::alu_op_t   aluOp,
  input  wire logic [4:0]              dstReg,
  input  wire logic [4:0]              srcReg,
  input  wire logic                    useImm,
  input  wire logic [7:0]              immValue,
  input  wire logic                    wideMove,
  input  wire logic                    twoWordInstr,
  input  wire logic                    jumpTaken,
  input  wire logic [15:0]             jumpTarget,
  input  wire cpu_core_pkg::stack_op_t stackOp,
  input  wire logic                    progWriteReq,
  input  wire logic                    tableRead,
  // indirect data access
  input  wire logic                    dataAccess,
  input  wire logic                    dataWrite,
  input  wire logic [1:0]              ptrSel,
  input  wire cpu_core_pkg::ptr_mode_t ptrMode,
  input  wire logic [5:0]              ptrDisp,
  input  wire logic                    ioShortForm,
  input  wire logic [5:0]              ioShortAddr,
  // data memory and io
  output logic [15:0]                  dataAddr,
  output logic [7:0]                   dataWrData,
  output logic                         dataWrEn,
  output logic                         dataRdEn,
  output cpu_core_pkg::space_t         dataSpace,
  input  wire logic [7:0]              dataRdData,
  // interrupts
  input  wire logic [15:0]             irqPending,
  // state
  output logic [7:0]                   statusFlags,
  output logic [15:0]                  stackPointer,
  output logic [15:0]                  progCounter,
  output logic [3:0]                   irqTaken
);
  regfile_if rf ();

  logic [15:0] spNow;
  logic [7:0]  next_statusFlags;
  logic [15:0] next_progCounter, next_progAddr;
  logic [15:0] next_dataAddr;
  logic [7:0]  next_dataWrData;
  logic        next_dataWrEn, next_dataRdEn;
  space_t      next_dataSpace;
  logic        next_progWriteOk;
  logic [3:0]  next_irqTaken;
  logic [7:0]  aluRes;
  logic        carryOut, halfOut, ovfOut;
  logic [15:0] ptrVal, ptrNew, effAddr;
  logic        irqGo, spWrLow, spWrHigh;
  stack_op_t   spOp;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic space_t classify(input logic [15:0] a);
    if (a <= {8'h00, `REGS_END})        return SPACE_REGS;
    else if (a <= {8'h00, `IO_END})     return SPACE_IO;
    else if (a <= {8'h00, `EXT_IO_END}) return SPACE_EXT_IO;
    else                                return SPACE_SRAM;
  endfunction

  function automatic logic [15:0] pick_ptr(input logic [1:0] s, input logic [47:0] p);
    unique case (s)
      2'd0:    return p[15:0];
      2'd1:    return p[31:16];
      default: return p[47:32];
    endcase
  endfunction

  function automatic logic [3:0] first_pending(input logic [15:0] p);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (p[i]) r = 4'(i);
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // register array and stack pointer
  // -----------------------------------------------------------------
  work_reg_array u_regs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .rf      (rf.array)
  );

  stack_ptr_unit u_stack (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .stackOp      (spOp),
    .wrLow        (spWrLow),
    .wrHigh       (spWrHigh),
    .wrByte       (rf.rdDataA),
    .stackPointer (spNow)
  );

  // -----------------------------------------------------------------
  // operand fetch and alu
  // -----------------------------------------------------------------
  assign rf.rdAddrA = dstReg;
  assign rf.rdAddrB = (dataAccess && classify(effAddr) == SPACE_REGS) ?
                      effAddr[4:0] : srcReg;
  assign irqGo      = statusFlags[`FLAG_I] && (irqPending != 16'h0000) && !jumpTaken;

  always_comb begin
    logic [8:0] sum;
    logic [7:0] a, b;
    sum      = 9'h000;
    a        = rf.rdDataA;
    b        = useImm ? immValue : rf.rdDataB;
    carryOut = statusFlags[`FLAG_C];
    halfOut  = statusFlags[`FLAG_H];
    ovfOut   = 1'b0;
    aluRes   = a;
    unique case (aluOp)
      ALU_ADD, ALU_ADC: begin
        sum      = {1'b0, a} + {1'b0, b} + {8'h00, aluOp == ALU_ADC && statusFlags[`FLAG_C]};
        aluRes   = sum[7:0];
        carryOut = sum[8];
        halfOut  = (a[3] & b[3]) | (b[3] & ~aluRes[3]) | (~aluRes[3] & a[3]);
        ovfOut   = (a[7] & b[7] & ~aluRes[7]) | (~a[7] & ~b[7] & aluRes[7]);
      end
      ALU_SUB, ALU_SBC: begin
        sum      = {1'b0, a} - {1'b0, b} - {8'h00, aluOp == ALU_SBC && statusFlags[`FLAG_C]};
        aluRes   = sum[7:0];
        carryOut = sum[8];
        halfOut  = (~a[3] & b[3]) | (b[3] & aluRes[3]) | (aluRes[3] & ~a[3]);
        ovfOut   = (a[7] & ~b[7] & ~aluRes[7]) | (~a[7] & b[7] & aluRes[7]);
      end
      ALU_AND:  aluRes = a & b;
      ALU_OR:   aluRes = a | b;
      ALU_XOR:  aluRes = a ^ b;
      ALU_MOV:  aluRes = b;
      ALU_COM: begin
        aluRes   = ~a;
        carryOut = 1'b1;
      end
      ALU_INC: begin
        aluRes = a + 8'h01;
        ovfOut = (a == 8'h7f);
      end
      ALU_DEC: begin
        aluRes = a - 8'h01;
        ovfOut = (a == 8'h80);
      end
      ALU_LSR: begin
        aluRes   = {1'b0, a[7:1]};
        carryOut = a[0];
        ovfOut   = a[0];
      end
      ALU_SWAP: aluRes = {a[3:0], a[7:4]};
      ALU_PASS: aluRes = a;
    endcase
  end

  // -----------------------------------------------------------------
  // pointer addressing and data space routing
  // -----------------------------------------------------------------
  always_comb begin
    ptrVal  = pick_ptr(ptrSel, rf.ptrPairs);
    ptrNew  = ptrVal;
    effAddr = ptrVal;
    unique case (ptrMode)
      PTR_POST_INC: ptrNew  = ptrVal + 16'h0001;
      PTR_PRE_DEC: begin
        ptrNew  = ptrVal - 16'h0001;
        effAddr = ptrNew;
      end
      PTR_DISP:     effAddr = ptrVal + {10'h000, ptrDisp};
      PTR_PLAIN:    effAddr = ptrVal;
    endcase
    if (ioShortForm) begin
      effAddr = {8'h00, `IO_BASE} + {10'h000, ioShortAddr};
    end
  end

  // register write port: alu result, word move, pointer update, or register-space data access
  always_comb begin
    rf.wrEn   = 1'b0;
    rf.wrWide = 1'b0;
    rf.wrAddr = dstReg;
    rf.wrData = {8'h00, aluRes};
    if (exValid && !irqGo) begin
      if (dataAccess && !ioShortForm &&
          (ptrMode == PTR_POST_INC || ptrMode == PTR_PRE_DEC)) begin
        rf.wrEn   = 1'b1;
        rf.wrWide = 1'b1;
        rf.wrAddr = `PTR_X_REG + {2'b00, ptrSel, 1'b0};
        rf.wrData = ptrNew;
      end else if (wideMove) begin
        rf.wrEn   = 1'b1;
        rf.wrWide = 1'b1;
        rf.wrData = {rf.rdDataB, rf.rdDataB};
        rf.wrAddr = dstReg;
      end else if (!dataAccess && aluOp != ALU_PASS && stackOp == STK_NONE) begin
        rf.wrEn   = 1'b1;
      end else if (dataAccess && classify(effAddr) == SPACE_REGS) begin
        rf.wrEn   = 1'b1;
        rf.wrAddr = dataWrite ? effAddr[4:0] : dstReg;
        rf.wrData = {8'h00, dataWrite ? rf.rdDataA : rf.rdDataB};
      end
    end
  end

  // -----------------------------------------------------------------
  // sequencing: prefetch, flags, stack, interrupts
  // -----------------------------------------------------------------
  always_comb begin
    next_progCounter = progCounter + (twoWordInstr ? 16'h0002 : 16'h0001);
    next_statusFlags = statusFlags;
    next_dataAddr    = dataAddr;
    next_dataWrData  = dataWrData;
    next_dataWrEn    = 1'b0;
    next_dataRdEn    = 1'b0;
    next_dataSpace   = dataSpace;
    next_progWriteOk = 1'b0;
    next_irqTaken    = irqTaken;
    spOp             = STK_NONE;
    spWrLow          = 1'b0;
    spWrHigh         = 1'b0;
    if (exValid) begin
      if (irqGo) begin
        spOp                        = STK_IRQ;
        next_irqTaken               = first_pending(irqPending);
        next_progCounter            = {11'h000, first_pending(irqPending), 1'b0};
        next_statusFlags[`FLAG_I]   = 1'b0;
        next_dataAddr               = spNow;
        next_dataWrData             = progCounter[7:0];
        next_dataWrEn               = 1'b1;
        next_dataSpace              = SPACE_SRAM;
      end else begin
        spOp = stackOp;
        if (stackOp == STK_CALL) begin
          next_dataAddr   = spNow;
          next_dataWrData = next_progCounter[7:0];
          next_dataWrEn   = 1'b1;
          next_dataSpace  = SPACE_SRAM;
        end
        if (stackOp == STK_IRET) begin
          next_statusFlags[`FLAG_I] = 1'b1;
        end
        if (jumpTaken) begin
          next_progCounter = jumpTarget;
        end
        if (!dataAccess && stackOp == STK_NONE && aluOp != ALU_PASS) begin
          next_statusFlags[`FLAG_C] = carryOut;
          next_statusFlags[`FLAG_H] = halfOut;
          next_statusFlags[`FLAG_V] = ovfOut;
          next_statusFlags[`FLAG_N] = aluRes[7];
          next_statusFlags[`FLAG_Z] = (aluRes == 8'h00);
          next_statusFlags[`FLAG_S] = aluRes[7] ^ ovfOut;
        end
        if (dataAccess) begin
          next_dataAddr   = effAddr;
          next_dataSpace  = classify(effAddr);
          next_dataWrData = rf.rdDataA;
          next_dataWrEn   = dataWrite && classify(effAddr) != SPACE_REGS;
          next_dataRdEn   = !dataWrite && classify(effAddr) != SPACE_REGS;
          if (dataWrite && classify(effAddr) == SPACE_IO) begin
            spWrLow  = effAddr[5:0] == (`IO_SP_LOW - 6'h20);
            spWrHigh = effAddr[5:0] == (`IO_SP_HIGH - 6'h20);
            if (effAddr[5:0] == (`IO_STATUS - 6'h20)) begin
              next_statusFlags = rf.rdDataA;
            end
          end
        end
        if (tableRead) begin
          next_dataAddr = pick_ptr(2'd2, rf.ptrPairs);
        end
        // a program write from the application section is simply dropped
        next_progWriteOk = progWriteReq && (progCounter >= `BOOT_START);
      end
    end
  end

  // program address leads execute by one: prefetch of the next word
  assign next_progAddr = tableRead ? {1'b0, rf.ptrPairs[47:33]} : next_progCounter;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      progCounter  <= 16'h0000;
      progAddr     <= 16'h0000;
      statusFlags  <= 8'h00;
      dataAddr     <= 16'h0000;
      dataWrData   <= 8'h00;
      dataWrEn     <= 1'b0;
      dataRdEn     <= 1'b0;
      dataSpace    <= SPACE_REGS;
      progWriteOk  <= 1'b0;
      irqTaken     <= 4'h0;
      stackPointer <= `SP_RESET;
    end else begin
      progCounter  <= next_progCounter;
      progAddr     <= next_progAddr;
      statusFlags  <= next_statusFlags;
      dataAddr     <= next_dataAddr;
      dataWrData   <= next_dataWrData;
      dataWrEn     <= next_dataWrEn;
      dataRdEn     <= next_dataRdEn;
      dataSpace    <= next_dataSpace;
      progWriteOk  <= next_progWriteOk;
      irqTaken     <= next_irqTaken;
      stackPointer <= spNow;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/mem_partner_model.sv ----
// program and data memory model facing the cpu core
`timescale 1ns/1ps
`default_nettype none
module mem_partner_model (
  // clock
  input  wire logic        clk_sys,
  // program side
  input  wire logic [15:0] progAddr,
  output var  logic [15:0] progData,
  // data side
  input  wire logic [15:0] dataAddr,
  input  wire logic [7:0]  dataWrData,
  input  wire logic        dataWrEn,
  input  wire logic        dataRdEn,
  output var  logic [7:0]  dataRdData
);
  logic [7:0] dataMem [0:1023];
  initial progData = 16'h0000;
  initial dataRdData = 8'h00;
  // a cycle without a read flips the byte, so stale data never looks valid
  always @(posedge clk_sys) begin
    progData <= progAddr ^ 16'h5a3c;
    if (dataWrEn) dataMem[dataAddr[9:0]] <= dataWrData;
    dataRdData <= dataRdEn ? dataMem[dataAddr[9:0]] : ~dataRdData;
  end
endmodule
`default_nettype wire

// ---- testbench/cpu_core_assertions.sv ----
// port checks of the cpu core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_map.svh"
module cpu_core_assertions
  import cpu_core_pkg::*;
(
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  // controls
  input wire logic                    exValid,
  input wire logic                    jumpTaken,
  input wire logic [15:0]             jumpTarget,
  input wire logic                    twoWordInstr,
  input wire cpu_core_pkg::stack_op_t stackOp,
  input wire logic                    progWriteReq,
  input wire logic [15:0]             irqPending,
  // results
  input wire logic                    progWriteOk,
  input wire logic                    dataWrEn,
  input wire logic [15:0]             dataAddr,
  input wire logic [7:0]              statusFlags,
  input wire logic [15:0]             stackPointer,
  input wire logic [15:0]             progCounter,
  input wire logic [3:0]              irqTaken
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic irqGo;
  logic plainOp;
  assign irqGo = exValid && statusFlags[`FLAG_I] && (|irqPending) && !jumpTaken;
  assign plainOp = exValid && !irqGo;
  function automatic logic [3:0] lowIdx(input logic [15:0] p);
    lowIdx = 4'h0;
    for (int i = 15; i >= 0; i--) if (p[i]) lowIdx = i[3:0];
  endfunction
  // stackPointer trails the internal pointer by one edge, hence ##2
  AST_PROG_WRITE_BOOT: assert property (progWriteOk |-> $past(exValid && progWriteReq)
    && $past(progCounter) >= `BOOT_START) else $error("program write outside boot");
  AST_PUSH_STEP: assert property (plainOp && stackOp == STK_PUSH
    |-> ##2 stackPointer == $past(stackPointer) - 16'h0001) else $error("push step");
  AST_POP_STEP: assert property (plainOp && stackOp == STK_POP
    |-> ##2 stackPointer == $past(stackPointer) + 16'h0001) else $error("pop step");
  AST_CALL_STEP: assert property ((plainOp && stackOp == STK_CALL) || irqGo
    |-> ##2 stackPointer == $past(stackPointer) - 16'h0002) else $error("call step");
  AST_RETURN_STEP: assert property (plainOp && stackOp inside {STK_RETURN, STK_IRET}
    |-> ##2 stackPointer == $past(stackPointer) + 16'h0002) else $error("return step");
  AST_CALL_PUSH: assert property (plainOp && stackOp == STK_CALL
    |=> dataWrEn && dataAddr == stackPointer) else $error("return address not stored");
  AST_IRQ_ENTRY: assert property (irqGo |=> !statusFlags[`FLAG_I]
    && irqTaken == lowIdx($past(irqPending))
    && progCounter == {11'h000, lowIdx($past(irqPending)), 1'b0}) else $error("irq entry");
  AST_IRQ_KEEPS_FLAGS: assert property (irqGo |=> statusFlags[6:0] == $past(statusFlags[6:0]))
    else $error("flags changed on irq entry");
  AST_IRET_SETS_I: assert property (plainOp && stackOp == STK_IRET |=> statusFlags[`FLAG_I])
    else $error("interrupt enable not restored");
  AST_PC_STEP: assert property (plainOp && !jumpTaken && stackOp == STK_NONE
    |=> progCounter == $past(progCounter) + ($past(twoWordInstr) ? 16'h0002 : 16'h0001))
    else $error("program counter step");
  AST_JUMP: assert property (exValid && jumpTaken |=> progCounter == $past(jumpTarget))
    else $error("jump target");
endmodule
bind cpu_regfile_stack_core cpu_core_assertions cpu_core_assertions_inst (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench of the cpu core datapath
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_map.svh"
module testbench;
  import cpu_core_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        exValid, useImm, wideMove, twoWordInstr, jumpTaken, progWriteReq;
  logic        tableRead, dataAccess, dataWrite, ioShortForm, progWriteOk;
  logic        dataWrEn, dataRdEn;
  alu_op_t     aluOp;
  stack_op_t   stackOp;
  ptr_mode_t   ptrMode;
  space_t      dataSpace;
  logic [4:0]  dstReg, srcReg;
  logic [7:0]  immValue, dataWrData, dataRdData, statusFlags;
  logic [1:0]  ptrSel;
  logic [5:0]  ptrDisp, ioShortAddr;
  logic [3:0]  irqTaken;
  logic [15:0] jumpTarget, irqPending, progAddr, progData, dataAddr, stackPointer, progCounter;
  int          failures = 0;
  int          checked = 0;
  int          sp = 32'h000002ff;
  logic [31:0] rng = 32'h000047a1;
  stack_op_t   ops[5] = '{STK_PUSH, STK_CALL, STK_POP, STK_RETURN, STK_CALL};
  int          dels[5] = '{-1, -2, 1, 2, -2};
  logic [15:0] zs[6] = '{16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100};
  space_t      sps[6] = '{SPACE_REGS, SPACE_IO, SPACE_IO, SPACE_EXT_IO, SPACE_EXT_IO, SPACE_SRAM};
  cpu_regfile_stack_core cpu_regfile_stack_core_inst (.*);
  mem_partner_model mem_partner_model_inst (.*);
  always #20 clk_sys = ~clk_sys;
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  function automatic logic [5:0] addFlags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic       v;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    v = (a[7] == b[7]) && (s[7] != a[7]);
    return {h[4], s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
  endfunction
  task automatic idle();
    {exValid, useImm, wideMove, twoWordInstr, jumpTaken, progWriteReq} = 6'h00;
    {tableRead, dataAccess, dataWrite, ioShortForm} = 4'h0;
    {dstReg, srcReg, immValue, ptrSel, ptrDisp, ioShortAddr} = 32'h00000000;
    {jumpTarget, irqPending} = 32'h00000000;
    aluOp = ALU_PASS;
    stackOp = STK_NONE;
    ptrMode = PTR_PLAIN;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
    idle();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic alu(input alu_op_t op, input logic [4:0] d, input logic [8:0] b);
    exValid = 1'b1;
    aluOp = op;
    dstReg = d;
    useImm = b[8];
    immValue = b[7:0];
    srcReg = b[4:0];
    tick();
  endtask
  task automatic stk(input stack_op_t op);
    exValid = 1'b1;
    stackOp = op;
    tick();
  endtask
  task automatic setZ(input logic [15:0] v);
    alu(ALU_MOV, 5'h1e, {1'b1, v[7:0]});
    alu(ALU_MOV, 5'h1f, {1'b1, v[15:8]});
  endtask
  task automatic ioWr(input logic [5:0] a, input logic [7:0] v);
    alu(ALU_MOV, 5'h18, {1'b1, v});
    {exValid, dataAccess, dataWrite, ioShortForm} = 4'hf;
    {dstReg, ioShortAddr} = {5'h18, a};
    tick();
  endtask
  task automatic acc(input logic [1:0] p, input ptr_mode_t m, input logic [5:0] d,
                     input logic [15:0] exp, input space_t s);
    exValid = 1'b1;
    dataAccess = 1'b1;
    ptrSel = p;
    ptrMode = m;
    ptrDisp = d;
    tick();
    chk(dataAddr, exp);
    chk({14'h0000, dataSpace}, {14'h0000, s});
    chk({15'h0000, dataRdEn}, {15'h0000, s != SPACE_REGS});
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    $display("Error at %0t: watchdog expired", $time);
    failures++;
    give_verdict();
  end
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] f;
    idle();
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk(stackPointer, `SP_RESET);
    exValid = 1'b1;
    progWriteReq = 1'b1;
    tick();
    chk({15'h0000, progWriteOk}, 16'h0000);
    chk(progCounter, 16'h0001);
    exValid = 1'b1;
    twoWordInstr = 1'b1;
    tick();
    chk(progCounter, 16'h0003);
    exValid = 1'b1;
    jumpTaken = 1'b1;
    jumpTarget = `BOOT_START;
    tick();
    exValid = 1'b1;
    progWriteReq = 1'b1;
    tick();
    chk({15'h0000, progWriteOk}, 16'h0001);
    $display("program flow test done");
    ioWr(6'h3e, 8'h01);
    ioWr(6'h3d, 8'h80);
    sp = 32'h00000180;
    // back to back: the visible pointer lags one op behind the model
    foreach (ops[i]) begin
      stk(ops[i]);
      chk(stackPointer, sp[15:0]);
      if (ops[i] == STK_CALL) chk(dataAddr, sp[15:0]);
      if (ops[i] == STK_CALL) chk({8'h00, dataWrData}, progCounter & 16'h00ff);
      sp += dels[i];
    end
    tick();
    chk(stackPointer, sp[15:0]);
    $display("stack test done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hff : rnd();
      b = (i == 0) ? 8'h01 : rnd();
      alu(ALU_MOV, 5'h10, {1'b1, a});
      alu(ALU_MOV, 5'h11, {1'b1, b});
      alu(ALU_ADD, 5'h10, i[0] ? {1'b1, b} : 9'h011);
      chk({10'h000, statusFlags[5:0]}, {10'h000, addFlags(a, b)});
    end
    $display("alu test done");
    foreach (zs[i]) begin
      setZ(zs[i]);
      acc(2'h2, PTR_PLAIN, 6'h00, zs[i], sps[i]);
    end
    setZ(16'h0150);
    acc(2'h2, PTR_POST_INC, 6'h00, 16'h0150, SPACE_SRAM);
    acc(2'h2, PTR_PLAIN, 6'h00, 16'h0151, SPACE_SRAM);
    acc(2'h2, PTR_PRE_DEC, 6'h00, 16'h0150, SPACE_SRAM);
    acc(2'h2, PTR_DISP, 6'h05, 16'h0155, SPACE_SRAM);
    exValid = 1'b1;
    tableRead = 1'b1;
    tick();
    chk(progAddr, 16'h00a8);
    wideMove = 1'b1;
    alu(ALU_MOV, 5'h1a, 9'h01e);
    acc(2'h0, PTR_PLAIN, 6'h00, 16'h5050, SPACE_SRAM);
    exValid = 1'b1;
    dataAccess = 1'b1;
    ioShortForm = 1'b1;
    ioShortAddr = 6'h3f;
    tick();
    chk(dataAddr, 16'h005f);
    $display("pointer test done");
    stk(STK_IRET);
    sp += 2;
    chk({15'h0000, statusFlags[7]}, 16'h0001);
    f = statusFlags;
    exValid = 1'b1;
    irqPending = {rnd(), 8'h14};
    tick();
    chk({12'h000, irqTaken}, 16'h0002);
    chk(progCounter, 16'h0004);
    chk({8'h00, statusFlags}, {9'h000, f[6:0]});
    exValid = 1'b1;
    irqPending = 16'h0001;
    tick();
    chk(progCounter, 16'h0005);
    chk(stackPointer, sp[15:0] - 16'h0002);
    $display("interrupt test done");
    give_verdict();
  end
endmodule
`default_nettype wire
